//--- design/usb_schedule_pkg.sv
// constants and types shared by the schedule traversal engine
package usb_schedule_pkg;
  // link pointer layout
  localparam int LINK_TERM_BIT = 0;
  localparam int LINK_QTYPE_BIT = 1;
  localparam int LINK_VF_BIT = 2;
  localparam int LINK_ADDR_LSB = 4;
  // byte offsets of words inside schedule structures
  localparam logic [31:0] HEAD_ELEM_OFFSET = 32'h0000_0004;
  localparam logic [31:0] DESC_STATUS_OFFSET = 32'h0000_0004;
  localparam int STATUS_ACTIVE_BIT = 23;
  localparam int ERR_CNT_W = 2;
  localparam int CNT_W = 16;
  // register map, byte addresses
  localparam int REG_ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FRAME_LINK = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FRAMES = 8'h0c;
  localparam logic [7:0] REG_ADVANCES = 8'h10;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_QCTX_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] FRAME_LINK_RESET = 32'h0000_0001;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RES_DATA, RES_ZERO_LEN, RES_ERROR, RES_NAK
  } exec_result_type;

  typedef enum logic [2:0] {
    S_IDLE, S_RD_DESC, S_RD_HEAD_H, S_RD_HEAD_E, S_EXEC, S_WB_STATUS,
    S_WB_ELEM
  } trav_state_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_type;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } exec_req_type;

  typedef struct packed {
    logic valid;
    exec_result_type result;
    logic [ERR_CNT_W-1:0] errLeft;
    logic [31:0] status;
  } exec_rsp_type;

  typedef struct packed {
    trav_state_type st;
    logic qCtx;
    logic [31:0] curAddr;
    logic [31:0] headAddr;
    logic [31:0] horizLink;
    logic [31:0] elemLink;
    logic [31:0] descLink;
    exec_result_type res;
    mem_req_type memReq;
    exec_req_type execReq;
    logic [CNT_W-1:0] frames;
    logic [CNT_W-1:0] advances;
    logic [31:0] ctrl;
    logic [31:0] frameLink;
    logic awRdy;
    logic wRdy;
    logic arRdy;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic [REG_ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
  } state_type;
endpackage : usb_schedule_pkg

//--- design/usb_schedule_queue_traversal.sv
// schedule walker: queue heads, element links, advance and write-back
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module usb_schedule_queue_traversal
  import usb_schedule_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [REG_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [REG_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic frameStart,
  output mem_req_type memReq,
  input wire logic memReady,
  input wire logic memRspValid,
  input wire logic [31:0] memRspData,
  output exec_req_type execReq,
  input wire exec_rsp_type execRsp
);

  state_type q;
  state_type d;

  function automatic logic [31:0] linkAddr(logic [31:0] lp);
    linkAddr = {lp[31:LINK_ADDR_LSB], {LINK_ADDR_LSB{1'b0}}};
  endfunction : linkAddr

  function automatic state_type issueRead(state_type s, logic [31:0] a,
                                          trav_state_type to);
    s.memReq.valid = 1'b1;
    s.memReq.write = 1'b0;
    s.memReq.addr = a;
    s.memReq.wdata = '0;
    s.st = to;
    return s;
  endfunction : issueRead

  function automatic state_type issueWrite(state_type s, logic [31:0] a,
                                           logic [31:0] v,
                                           trav_state_type to);
    s.memReq.valid = 1'b1;
    s.memReq.write = 1'b1;
    s.memReq.addr = a;
    s.memReq.wdata = v;
    s.st = to;
    return s;
  endfunction : issueWrite

  // follow a link to the next schedule item, or close the frame
  function automatic state_type followLink(state_type s, logic [31:0] lp);
    if (lp[LINK_TERM_BIT])
    begin
      s.st = S_IDLE;
      s.qCtx = 1'b0;
      s.frames = s.frames + 1'b1;
    end
    else if (lp[LINK_QTYPE_BIT])
    begin
      // the head is cached and context set before its words arrive
      s.headAddr = linkAddr(lp);
      s.qCtx = 1'b1;
      s.curAddr = linkAddr(lp);
      s = issueRead(s, linkAddr(lp), S_RD_HEAD_H);
    end
    else
    begin
      s.qCtx = 1'b0;
      s.curAddr = linkAddr(lp);
      s = issueRead(s, linkAddr(lp), S_RD_DESC);
    end
    return s;
  endfunction : followLink

  // decide on the top member of the queue in context
  function automatic state_type queueStep(state_type s);
    if (s.elemLink[LINK_TERM_BIT])
      s = followLink(s, s.horizLink);
    else if (s.elemLink[LINK_QTYPE_BIT])
      // old element word is never written when a nested head is entered
      s = followLink(s, s.elemLink);
    else
    begin
      s.curAddr = linkAddr(s.elemLink);
      s = issueRead(s, linkAddr(s.elemLink), S_RD_DESC);
    end
    return s;
  endfunction : queueStep

  function automatic logic [31:0] applyStrb(logic [31:0] old,
                                            logic [31:0] v,
                                            logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = v[i*8 +: 8];
    end
    return r;
  endfunction : applyStrb

  logic advOk;
  logic keepActive;
  logic [31:0] statWb;
  assign advOk = (q.res == RES_DATA) || (q.res == RES_ZERO_LEN);
  // nak retries untouched; an error stays live until its count runs out
  assign keepActive = (execRsp.result == RES_NAK) ||
                      ((execRsp.result == RES_ERROR) &&
                       (execRsp.errLeft != '0));

  always_comb
  begin
    d = q;
    statWb = execRsp.status;
    statWb[STATUS_ACTIVE_BIT] = keepActive;
    // memory master: one access at a time, request dropped once taken
    if (q.memReq.valid && memReady)
      d.memReq.valid = 1'b0;
    unique case (q.st)
      S_IDLE:
      begin
        if (frameStart && q.ctrl[CTRL_ENABLE_BIT])
        begin
          d.qCtx = 1'b0;
          d = followLink(d, q.frameLink);
        end
      end
      S_RD_HEAD_H:
      begin
        if (memRspValid)
        begin
          d.horizLink = memRspData;
          d = issueRead(d, q.headAddr + HEAD_ELEM_OFFSET, S_RD_HEAD_E);
        end
      end
      S_RD_HEAD_E:
      begin
        if (memRspValid)
        begin
          d.elemLink = memRspData;
          d = queueStep(d);
        end
      end
      S_RD_DESC:
      begin
        if (memRspValid)
        begin
          d.descLink = memRspData;
          d.execReq.valid = 1'b1;
          d.execReq.addr = q.curAddr;
          d.st = S_EXEC;
        end
      end
      S_EXEC:
      begin
        if (execRsp.valid)
        begin
          d.execReq.valid = 1'b0;
          d.res = execRsp.result;
          d = issueWrite(d, q.curAddr + DESC_STATUS_OFFSET, statWb,
                         S_WB_STATUS);
        end
      end
      S_WB_STATUS:
      begin
        if (memReady)
        begin
          if (q.qCtx && advOk)
          begin
            d.advances = q.advances + 1'b1;
            d.elemLink = q.descLink;
            d = issueWrite(d, q.headAddr + HEAD_ELEM_OFFSET, q.descLink,
                           S_WB_ELEM);
          end
          else if (q.qCtx)
            d = followLink(d, q.horizLink);
          else
            d = followLink(d, q.descLink);
        end
      end
      S_WB_ELEM:
      begin
        if (memReady)
        begin
          // with the VF bit set the fresh element word is the new top and the queue step re-runs; otherwise the horizontal link is followed
          if (q.descLink[LINK_VF_BIT])
            d = queueStep(d);
          else
            d = followLink(d, q.horizLink);
        end
      end
    endcase

    // register slave: address and data latched in either order
    if (awvalid && q.awRdy)
    begin
      d.awRdy = 1'b0;
      d.awAddr = awaddr;
    end
    if (wvalid && q.wRdy)
    begin
      d.wRdy = 1'b0;
      d.wData = wdata;
      d.wStrb = wstrb;
    end
    if (!q.awRdy && !q.wRdy && !q.bValid)
    begin
      d.bValid = 1'b1;
      d.bResp = AXI_OKAY;
      d.awRdy = 1'b1;
      d.wRdy = 1'b1;
      unique case (q.awAddr)
        REG_CTRL: d.ctrl = applyStrb(q.ctrl, q.wData, q.wStrb);
        REG_FRAME_LINK:
          d.frameLink = applyStrb(q.frameLink, q.wData, q.wStrb);
        REG_STATUS, REG_FRAMES, REG_ADVANCES: d.bResp = AXI_OKAY;
        default: d.bResp = AXI_SLVERR;
      endcase
    end
    if (q.bValid && bready)
      d.bValid = 1'b0;
    if (arvalid && q.arRdy)
    begin
      d.arRdy = 1'b0;
      d.rValid = 1'b1;
      d.rResp = AXI_OKAY;
      d.rData = '0;
      unique case (araddr)
        REG_CTRL: d.rData = q.ctrl;
        REG_FRAME_LINK: d.rData = q.frameLink;
        REG_STATUS:
        begin
          d.rData[STATUS_BUSY_BIT] = (q.st != S_IDLE);
          d.rData[STATUS_QCTX_BIT] = q.qCtx;
        end
        REG_FRAMES: d.rData[CNT_W-1:0] = q.frames;
        REG_ADVANCES: d.rData[CNT_W-1:0] = q.advances;
        default: d.rResp = AXI_SLVERR;
      endcase
    end
    if (q.rValid && rready)
    begin
      d.rValid = 1'b0;
      d.arRdy = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
      q.st <= S_IDLE;
      q.res <= RES_DATA;
      q.ctrl <= CTRL_RESET;
      q.frameLink <= FRAME_LINK_RESET;
      q.awRdy <= 1'b1;
      q.wRdy <= 1'b1;
      q.arRdy <= 1'b1;
    end
    else
      q <= d;
  end

  assign awready = q.awRdy;
  assign wready = q.wRdy;
  assign bvalid = q.bValid;
  assign bresp = q.bResp;
  assign arready = q.arRdy;
  assign rvalid = q.rValid;
  assign rresp = q.rResp;
  assign rdata = q.rData;
  assign memReq = q.memReq;
  assign execReq = q.execReq;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  logic nestCase;
  assign nestCase = (q.st == S_RD_HEAD_E) && memRspValid &&
                    !memRspData[LINK_TERM_BIT] && memRspData[LINK_QTYPE_BIT];

  headPair_a: assert property (
    (q.st == S_RD_HEAD_E && q.memReq.valid) |->
      !q.memReq.write && q.memReq.addr == q.headAddr + HEAD_ELEM_OFFSET)
    else $error("element word not read beside head");

  nestedHead_a: assert property (
    nestCase |=> q.st == S_RD_HEAD_H && q.qCtx &&
      q.memReq.addr == linkAddr($past(memRspData)))
    else $error("nested head not fetched");

  nestNoWrite_a: assert property (
    nestCase |=> (!q.memReq.write) [*2])
    else $error("element word written on nested entry");

  emptyQueue_a: assert property (
    ((q.st == S_RD_HEAD_E) && memRspValid && memRspData[LINK_TERM_BIT]
      && q.horizLink[LINK_TERM_BIT]) |=> q.st == S_IDLE && !q.execReq.valid)
    else $error("empty terminal queue did not end frame");

  statusWb_a: assert property (
    (q.st == S_EXEC && execRsp.valid) |=> q.memReq.valid && q.memReq.write
      && q.memReq.addr == q.curAddr + DESC_STATUS_OFFSET
      && q.memReq.wdata[STATUS_ACTIVE_BIT] == $past(keepActive))
    else $error("descriptor status write-back wrong");

  elemWb_a: assert property (
    (q.st == S_WB_ELEM && q.memReq.valid) |-> q.memReq.write &&
      q.memReq.addr == q.headAddr + HEAD_ELEM_OFFSET &&
      q.memReq.wdata == q.descLink)
    else $error("element write-back wrong");

  noAdvance_a: assert property (
    (q.st == S_WB_STATUS && memReady && q.qCtx && !advOk) |=>
      q.st != S_WB_ELEM && q.advances == $past(q.advances))
    else $error("queue advanced on failed completion");

  depthFirst_a: assert property (
    (q.st == S_WB_ELEM && memReady && q.descLink[LINK_VF_BIT] &&
      !q.descLink[LINK_TERM_BIT] && !q.descLink[LINK_QTYPE_BIT]) |=>
      q.st == S_RD_DESC && q.memReq.addr == linkAddr($past(q.descLink)))
    else $error("depth-first did not follow descriptor link");

  breadthEnd_a: assert property (
    (q.st == S_WB_ELEM && memReady && !q.descLink[LINK_VF_BIT] &&
      q.horizLink[LINK_TERM_BIT]) |=> q.st == S_IDLE)
    else $error("breadth-first terminal queue kept walking");

  plainDesc_a: assert property (
    (q.st == S_WB_STATUS && memReady && !q.qCtx &&
      q.descLink[LINK_TERM_BIT]) |=> q.st == S_IDLE && !q.qCtx)
    else $error("terminate after plain descriptor ignored");

  depthCov_c: cover property (
    q.st == S_WB_ELEM && memReady && q.descLink[LINK_VF_BIT]);
  nestCov_c: cover property (nestCase);
  emptyCov_c: cover property (
    q.st == S_RD_HEAD_E && memRspValid && memRspData[LINK_TERM_BIT]);
  retryCov_c: cover property (
    q.st == S_WB_STATUS && memReady && q.qCtx && !advOk);

endmodule : usb_schedule_queue_traversal

//--- verification/sched_mem_model.sv
// system memory model holding the schedule structures
`timescale 1ns/10ps
module sched_mem_model
  import usb_schedule_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic slow,
  input wire mem_req_type memReq,
  output logic memReady,
  output logic memRspValid,
  output logic [31:0] memRspData
);
  logic [31:0] mem [0:255];
  logic [31:0] pendData;
  logic pend;
  int waitCnt;

  // word index of an aligned address, flag bits never reach memory
  function automatic int idx(input logic [31:0] a);
    return int'(a[9:2]);
  endfunction : idx

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      memReady <= 1'b0;
      memRspValid <= 1'b0;
      memRspData <= 32'h5a5a_5a5a;
      pend <= 1'b0;
      waitCnt <= 0;
    end
    else
    begin
      // idle data keeps toggling so a stale word never looks valid
      memRspData <= ~memRspData;
      memReady <= slow ? 1'($urandom_range(1)) : 1'b1;
      memRspValid <= pend && waitCnt == 0;
      if (pend && waitCnt == 0)
      begin
        memRspData <= pendData;
        pend <= 1'b0;
      end
      else if (pend)
        waitCnt <= waitCnt - 1;
      if (memReq.valid && memReady)
      begin
        if (memReq.write)
          mem[idx(memReq.addr)] <= memReq.wdata;
        else
        begin
          pend <= 1'b1;
          pendData <= mem[idx(memReq.addr)];
          waitCnt <= slow ? int'($urandom_range(4)) : 0;
        end
      end
    end
  end
endmodule : sched_mem_model

//--- verification/usb_schedule_queue_traversal_tb_top.sv
// self-checking bench for the schedule traversal engine
`timescale 1ns/10ps
`define CHK(a, e) \
  begin \
    n_compared++; \
    if ((a) !== (e)) \
    begin \
      failures++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end
module usb_schedule_queue_traversal_tb_top
  import usb_schedule_pkg::*;
;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [REG_ADDR_W-1:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, frameStart = 1'b0, slow = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic memReady, memRspValid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, memRspData;
  mem_req_type memReq;
  exec_req_type execReq;
  exec_rsp_type execRsp = '0;
  exec_result_type curRes = RES_DATA;
  logic [1:0] curErr = 2'h0;
  logic [31:0] lastStat = 32'h0;
  logic [31:0] execLog [$];
  int failures = 0, n_compared = 0, cyc = 0, expAdv = 0, expFrm = 0;

  usb_schedule_queue_traversal i_usb_schedule_queue_traversal (
    .ref_clk, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .frameStart, .memReq,
    .memReady, .memRspValid, .memRspData, .execReq, .execRsp
  );
  sched_mem_model i_sched_mem_model (
    .ref_clk, .arst_n, .slow, .memReq, .memReady, .memRspValid,
    .memRspData
  );

  always #2 ref_clk = ~ref_clk;

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  // a walk takes a few hundred cycles at most
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      failures++;
      summarize();
    end
  end

  // executor: answers after a random delay, logs what it ran
  initial
  forever
  begin
    @(posedge ref_clk);
    if (execReq.valid === 1'b1 && execRsp.valid !== 1'b1)
    begin
      execLog.push_back(execReq.addr);
      lastStat = $urandom;
      repeat ($urandom_range(3)) @(posedge ref_clk);
      execRsp <= '{1'b1, curRes, curErr, lastStat};
    end
    else
      execRsp.valid <= 1'b0;
  end

  function automatic logic advances(input exec_result_type r);
    return r == RES_DATA || r == RES_ZERO_LEN;
  endfunction : advances

  function automatic logic [31:0] stat_exp(input exec_result_type r,
    input logic [1:0] e, input logic [31:0] s);
    stat_exp = s;
    stat_exp[STATUS_ACTIVE_BIT] = r == RES_NAK || (r == RES_ERROR && e != 0);
  endfunction : stat_exp

  task automatic put(input logic [11:0] a, input logic [31:0] v);
    i_sched_mem_model.mem[a[9:2]] = v;
  endtask : put

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] rs);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] rs);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // one frame walk; x0/x1 expected executions, ha head whose element is ev
  task automatic run_frame(input logic [31:0] fl, x0, x1, ha, ev,
    input exec_result_type r, input logic [1:0] e);
    logic [31:0] d;
    logic [31:0] last;
    logic [1:0] rs;
    curRes = r;
    curErr = e;
    execLog.delete();
    axi_wr(REG_FRAME_LINK, fl, rs);
    @(posedge ref_clk);
    frameStart <= 1'b1;
    slow <= 1'($urandom_range(1));
    @(posedge ref_clk);
    frameStart <= 1'b0;
    repeat (2) @(posedge ref_clk);
    d = 32'h1;
    while (d[STATUS_BUSY_BIT] !== 1'b0)
      axi_rd(REG_STATUS, d, rs);
    expFrm++;
    repeat (3) execLog.push_back(32'h0);
    `CHK(execLog[0], x0)
    `CHK(execLog[1], x1)
    `CHK(execLog[2], 32'h0)
    if (ha != 0)
      `CHK(i_sched_mem_model.mem[ha[9:2] + 8'h1], ev)
    last = x1 != 0 ? x1 : x0;
    if (last != 0)
      `CHK(i_sched_mem_model.mem[last[9:2] + 8'h1],
        stat_exp(r, e, lastStat))
  endtask : run_frame

  initial
  begin
    logic [31:0] d;
    logic [1:0] rs;
    exec_result_type r;
    logic [1:0] e;
    void'($urandom(27217));
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    `CHK({awready, wready, arready, bvalid, rvalid}, 5'h1c)
    put(12'h100, 32'h112);
    put(12'h104, 32'h200);
    put(12'h110, 32'h001);
    put(12'h114, 32'h001);
    put(12'h200, 32'h210);
    put(12'h210, 32'h001);
    put(12'h120, 32'h001);
    put(12'h124, 32'h220);
    put(12'h220, 32'h234);
    put(12'h230, 32'h001);
    put(12'h130, 32'h001);
    put(12'h134, 32'h142);
    put(12'h140, 32'h001);
    put(12'h144, 32'h240);
    put(12'h240, 32'h001);
    put(12'h250, 32'h260);
    put(12'h260, 32'h112);
    axi_rd(REG_CTRL, d, rs);
    `CHK(d, CTRL_RESET)
    axi_rd(REG_FRAME_LINK, d, rs);
    `CHK(d, FRAME_LINK_RESET)
    axi_rd(8'h40, d, rs);
    `CHK({rs, d}, {AXI_SLVERR, 32'h0})
    axi_wr(8'h44, 32'h1, rs);
    `CHK(rs, AXI_SLVERR)
    axi_wr(REG_FRAMES, 32'h1234, rs);
    `CHK(rs, AXI_OKAY)
    // only byte 1 enabled: the other bytes keep their reset value
    wstrb <= 4'h2;
    axi_wr(REG_FRAME_LINK, 32'hffff_abff, rs);
    wstrb <= 4'hf;
    axi_rd(REG_FRAME_LINK, d, rs);
    `CHK(d, FRAME_LINK_RESET | 32'h0000_ab00)
    // walk refused while the engine is disabled
    run_frame(32'h102, 32'h0, 32'h0, 32'h100, 32'h200, RES_DATA, 2'h1);
    expFrm = 0;
    axi_wr(REG_CTRL, 32'h1, rs);
    run_frame(32'h102, 32'h200, 32'h0, 32'h100, 32'h210,
      RES_DATA, 2'h1);
    run_frame(32'h102, 32'h210, 32'h0, 32'h100, 32'h210,
      RES_NAK, 2'h2);
    run_frame(32'h102, 32'h210, 32'h0, 32'h100, 32'h210,
      RES_ERROR, 2'h0);
    run_frame(32'h102, 32'h210, 32'h0, 32'h100, 32'h001,
      RES_ZERO_LEN, 2'h1);
    run_frame(32'h102, 32'h0, 32'h0, 32'h100, 32'h001,
      RES_DATA, 2'h1);
    expAdv = 2;
    repeat (8)
    begin
      r = exec_result_type'($urandom_range(3));
      e = 2'($urandom_range(3));
      put(12'h104, 32'h200);
      expAdv += int'(advances(r));
      run_frame(32'h102, 32'h200, 32'h0, 32'h100,
        advances(r) ? 32'h210 : 32'h200, r, e);
    end
    run_frame(32'h122, 32'h220, 32'h230, 32'h120, 32'h001,
      RES_DATA, 2'h1);
    run_frame(32'h132, 32'h240, 32'h0, 32'h130, 32'h142,
      RES_DATA, 2'h1);
    `CHK(i_sched_mem_model.mem[8'h51], 32'h001)
    run_frame(32'h250, 32'h250, 32'h260, 32'h0, 32'h0,
      RES_DATA, 2'h1);
    expAdv += 3;
    axi_rd(REG_ADVANCES, d, rs);
    `CHK(d, 32'(expAdv))
    axi_rd(REG_FRAMES, d, rs);
    `CHK(d, 32'(expFrm))
    // reset again mid-run: control and counters fall back to idle values
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    axi_rd(REG_CTRL, d, rs);
    `CHK(d, CTRL_RESET)
    axi_rd(REG_ADVANCES, d, rs);
    `CHK(d, 32'h0)
    summarize();
  end
endmodule : usb_schedule_queue_traversal_tb_top
